// File: pkg/opbuf_map.svh
/*
 Constants of the operand buffer and shift datapath: register offsets,
 field positions, reset values and select codes.
 Assumes inclusion by bare name from the package and the core.
*/
`ifndef OPBUF_MAP_SVH
`define OPBUF_MAP_SVH

// ----------------------------------------------------------------
// word and reset values
// ----------------------------------------------------------------
`define OPBUF_WORD_ZERO      16'h0000
`define OPBUF_STATUS_PAD     12'h000
`define OPBUF_CTRL_RESET     1'h0

// ----------------------------------------------------------------
// shift select codes of the working register
// ----------------------------------------------------------------
`define OPBUF_SEL_HOLD       2'h0
`define OPBUF_SEL_RIGHT      2'h1
`define OPBUF_SEL_LEFT       2'h2
`define OPBUF_SEL_LOAD       2'h3

// ----------------------------------------------------------------
// read-return select codes
// ----------------------------------------------------------------
`define OPBUF_RET_STATUS     2'h0
`define OPBUF_RET_WORKING    2'h1
`define OPBUF_RET_PAIR       2'h2
`define OPBUF_RET_BUFFER     2'h3

// ----------------------------------------------------------------
// general-purpose control code that routes the float high msb
// ----------------------------------------------------------------
`define OPBUF_GPC_FLOAT_MSB  3'h5

// ----------------------------------------------------------------
// avalon register map (byte addresses) and fields
// ----------------------------------------------------------------
`define OPBUF_ADDR_CTRL      4'h0
`define OPBUF_ADDR_BUFFER    4'h4
`define OPBUF_ADDR_WORKING   4'h8
`define OPBUF_ADDR_RETURN    4'hc
`define OPBUF_CTRL_FLOAT_BIT 0
`define OPBUF_DATA_ZERO      32'h0000_0000
`define OPBUF_PAD16          16'h0000
`define OPBUF_PAD31          31'h0000_0000

`endif

// File: pkg/opbuf_pkg.sv
/*
 Types of the operand buffer and shift datapath.
 Assumes the map header sits beside it on the include path.
*/
`default_nettype none
`include "opbuf_map.svh"

package opbuf_pkg;

   // ----------------------------------------------------------------
   // pins from the host processor microword and timing generator
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        first_timing_pulse;
      logic        second_timing_pulse;
      logic        third_timing_pulse;
      logic        buffer_load_en;
      logic        shift_select_hi;
      logic        shift_select_lo;
      logic [2:0]  general_purpose_ctl_code;
      logic        combined_arith_shift;
      logic        multiply_active;
      logic        divide_active;
      logic        alu_result_bit0;
      logic        quotient_bit;
      logic        float_high_msb;
      logic [1:0]  read_return_sel;
      logic [3:0]  extension_status_flags;
      logic [15:0] cpu_data_mux;
   } pin_in_t;

   // ----------------------------------------------------------------
   // contents exported to the rest of the extension
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] operand_buffer;
      logic [15:0] working_shift_reg;
   } datapath_out_t;

endpackage
`default_nettype wire

// File: core/operand_buffer_shift_datapath.sv
/*
 Operand buffer, working shift register and read-return multiplexer of
 an arithmetic instruction extension, with a small Avalon-MM slave.
 Assumes the processor pins are asynchronous to CLOCK and that every
 timing pulse stays high and low for at least two CLOCK periods.
*/
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "opbuf_map.svh"

module operand_buffer_shift_datapath (
   input  wire logic                    CLOCK,
   input  wire logic                    RESET,
   input  wire opbuf_pkg::pin_in_t      PINS,
   output logic [15:0]                  READ_BUS,
   output opbuf_pkg::datapath_out_t     DATAPATH,
   input  wire logic [3:0]              AVS_ADDRESS,
   input  wire logic                    AVS_READ,
   input  wire logic                    AVS_WRITE,
   input  wire logic [3:0]              AVS_BYTEENABLE,
   input  wire logic [31:0]             AVS_WRITEDATA,
   output logic [31:0]                  AVS_READDATA,
   output logic                         AVS_WAITREQUEST
);
   import opbuf_pkg::*;

   // ----------------------------------------------------------------
   // pin synchroniser and pulse edge detection
   // ----------------------------------------------------------------
   pin_in_t     meta_reg;
   pin_in_t     sync_reg;
   pin_in_t     prev_reg;
   logic        fall_first;
   logic        fall_second;
   logic        fall_third;

   // two flops for every pin, a third stage to find the trailing edge
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end else begin
         meta_reg <= PINS;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // trailing edges; prev_reg holds the controls seen while the pulse was high
   assign fall_first  = prev_reg.first_timing_pulse  & ~sync_reg.first_timing_pulse;
   assign fall_second = prev_reg.second_timing_pulse & ~sync_reg.second_timing_pulse;
   assign fall_third  = prev_reg.third_timing_pulse  & ~sync_reg.third_timing_pulse;

   // ----------------------------------------------------------------
   // control register (software side)
   // ----------------------------------------------------------------
   logic        float_fitted_reg;
   logic        float_fitted_next;
   logic        ack_reg;
   logic        ack_next;
   logic [31:0] readdata_reg;
   logic [31:0] readdata_next;
   logic [15:0] read_bus_reg;
   logic [15:0] read_bus_next;

   // ----------------------------------------------------------------
   // operand buffer and working shift register
   // ----------------------------------------------------------------
   logic [15:0] operand_buffer_reg;
   logic [15:0] operand_buffer_next;
   logic [15:0] working_shift_reg;
   logic [15:0] working_shift_next;
   logic [1:0]  shift_select;
   logic        buffer_load_clock;
   logic        working_clock;
   logic        left_in;
   logic        right_in;

   assign shift_select      = {prev_reg.shift_select_hi, prev_reg.shift_select_lo};
   assign buffer_load_clock = (fall_first | fall_third) & prev_reg.buffer_load_en;
   assign working_clock     = fall_first | fall_second;

   // serial input at bit 0, used only by left shifts
   always_comb begin
      if (prev_reg.combined_arith_shift) begin
         left_in = 1'b0;
      end else if (float_fitted_reg &&
                   prev_reg.general_purpose_ctl_code == `OPBUF_GPC_FLOAT_MSB) begin
         left_in = prev_reg.float_high_msb;
      end else if (prev_reg.divide_active) begin
         left_in = prev_reg.quotient_bit;
      end else begin
         left_in = 1'b0;
      end
   end

   // serial input at bit 15, used only by right shifts
   always_comb begin
      if (prev_reg.multiply_active) begin
         right_in = prev_reg.alu_result_bit0;
      end else begin
         right_in = operand_buffer_reg[0];
      end
   end

   // next values of the two datapath registers
   always_comb begin
      operand_buffer_next = operand_buffer_reg;
      working_shift_next  = working_shift_reg;
      if (buffer_load_clock) begin
         operand_buffer_next = prev_reg.cpu_data_mux;
      end
      if (working_clock) begin
         case (shift_select)
            `OPBUF_SEL_HOLD: begin
               working_shift_next = working_shift_reg;
            end
            `OPBUF_SEL_RIGHT: begin
               working_shift_next = {right_in, working_shift_reg[15:1]};
            end
            `OPBUF_SEL_LEFT: begin
               working_shift_next = {working_shift_reg[14:0], left_in};
            end
            `OPBUF_SEL_LOAD: begin
               working_shift_next = operand_buffer_reg;
            end
            default: begin
               working_shift_next = working_shift_reg;
            end
         endcase
      end
   end

   // register stage of the datapath
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         operand_buffer_reg <= `OPBUF_WORD_ZERO;
         working_shift_reg  <= `OPBUF_WORD_ZERO;
      end else begin
         operand_buffer_reg <= operand_buffer_next;
         working_shift_reg  <= working_shift_next;
      end
   end

   // continuous export for other extension logic and test
   assign DATAPATH.operand_buffer    = operand_buffer_reg;
   assign DATAPATH.working_shift_reg = working_shift_reg;

   // ----------------------------------------------------------------
   // read-return multiplexer onto the processor read bus
   // ----------------------------------------------------------------
   function automatic logic [15:0] return_word(input logic [1:0]  sel,
                                               input logic [3:0]  flags,
                                               input logic [15:0] buf_word,
                                               input logic [15:0] work_word);
      logic [15:0] word;
      word = `OPBUF_WORD_ZERO;
      case (sel)
         `OPBUF_RET_STATUS:  word = {`OPBUF_STATUS_PAD, flags};
         `OPBUF_RET_WORKING: word = work_word;
         `OPBUF_RET_PAIR:    word = {buf_word[14:0], work_word[15]};
         `OPBUF_RET_BUFFER:  word = buf_word;
         default:            word = `OPBUF_WORD_ZERO;
      endcase
      return word;
   endfunction

   // return word chosen by the synchronised select
   always_comb begin
      read_bus_next = return_word(sync_reg.read_return_sel, sync_reg.extension_status_flags,
                                  operand_buffer_reg, working_shift_reg);
   end

   // register the read bus
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         read_bus_reg <= `OPBUF_WORD_ZERO;
      end else begin
         read_bus_reg <= read_bus_next;
      end
   end

   assign READ_BUS = read_bus_reg;

   // ----------------------------------------------------------------
   // avalon-mm slave: one wait state per access
   // ----------------------------------------------------------------
   // next acknowledge, control bit and read data; writes land in the wait-free cycle
   always_comb begin
      ack_next          = (AVS_READ | AVS_WRITE) & ~ack_reg;
      float_fitted_next = float_fitted_reg;
      readdata_next     = readdata_reg;
      if (AVS_WRITE && ack_reg && AVS_ADDRESS == `OPBUF_ADDR_CTRL && AVS_BYTEENABLE[0]) begin
         float_fitted_next = AVS_WRITEDATA[`OPBUF_CTRL_FLOAT_BIT];
      end
      if (AVS_READ && !ack_reg) begin
         case (AVS_ADDRESS)
            `OPBUF_ADDR_CTRL:    readdata_next = {`OPBUF_PAD31, float_fitted_reg};
            `OPBUF_ADDR_BUFFER:  readdata_next = {`OPBUF_PAD16, operand_buffer_reg};
            `OPBUF_ADDR_WORKING: readdata_next = {`OPBUF_PAD16, working_shift_reg};
            `OPBUF_ADDR_RETURN:  readdata_next = {`OPBUF_PAD16, read_bus_reg};
            default:             readdata_next = `OPBUF_DATA_ZERO;
         endcase
      end
   end

   // register stage of the bus slave
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         ack_reg          <= 1'b0;
         float_fitted_reg <= `OPBUF_CTRL_RESET;
         readdata_reg     <= `OPBUF_DATA_ZERO;
      end else begin
         ack_reg          <= ack_next;
         float_fitted_reg <= float_fitted_next;
         readdata_reg     <= readdata_next;
      end
   end

   // wait only in the first cycle of a request
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
   assign AVS_READDATA    = readdata_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_buffer_load_edge: assert property (@(posedge CLOCK) disable iff (RESET)
      (buffer_load_clock) |=> (operand_buffer_reg == $past(prev_reg.cpu_data_mux)))
      else $error("buffer missed a load on a trailing pulse edge");

   a_buffer_holds_idle: assert property (@(posedge CLOCK) disable iff (RESET)
      (!buffer_load_clock) |=> $stable(operand_buffer_reg))
      else $error("buffer changed without a load");

   a_working_no_pulse: assert property (@(posedge CLOCK) disable iff (RESET)
      (!(fall_first || fall_second)) |=> $stable(working_shift_reg))
      else $error("working register changed off pulse one or two");

   a_working_hold_code: assert property (@(posedge CLOCK) disable iff (RESET)
      (working_clock && shift_select == `OPBUF_SEL_HOLD) |=> $stable(working_shift_reg))
      else $error("hold code changed the working register");

   a_working_par_load: assert property (@(posedge CLOCK) disable iff (RESET)
      (working_clock && shift_select == `OPBUF_SEL_LOAD && !buffer_load_clock)
      |=> (working_shift_reg == operand_buffer_reg))
      else $error("parallel load did not copy the buffer");

   a_right_top_bit: assert property (@(posedge CLOCK) disable iff (RESET)
      (working_clock && shift_select == `OPBUF_SEL_RIGHT && !prev_reg.multiply_active)
      |=> (working_shift_reg[15] == $past(operand_buffer_reg[0])
           && working_shift_reg[14:0] == $past(working_shift_reg[15:1])))
      else $error("right shift did not take buffer bit zero");

   a_mult_top_bit: assert property (@(posedge CLOCK) disable iff (RESET)
      (working_clock && shift_select == `OPBUF_SEL_RIGHT && prev_reg.multiply_active)
      |=> (working_shift_reg[15] == $past(prev_reg.alu_result_bit0)))
      else $error("multiply shift did not take alu bit zero");

   a_combined_arith_shift_zero_in: assert property (@(posedge CLOCK) disable iff (RESET)
      (working_clock && shift_select == `OPBUF_SEL_LEFT && prev_reg.combined_arith_shift)
      |=> (working_shift_reg[0] == 1'b0))
      else $error("combined shift brought in a one");

   a_float_msb_gate: assert property (@(posedge CLOCK) disable iff (RESET)
      (working_clock && shift_select == `OPBUF_SEL_LEFT && !float_fitted_reg
       && !prev_reg.divide_active) |=> (working_shift_reg[0] == 1'b0))
      else $error("float source used without the float extension");

   a_return_pair: assert property (@(posedge CLOCK) disable iff (RESET)
      (sync_reg.read_return_sel == `OPBUF_RET_PAIR)
      |=> (READ_BUS == {$past(operand_buffer_reg[14:0]), $past(working_shift_reg[15])}))
      else $error("pair return not shifted left one");

   a_return_status: assert property (@(posedge CLOCK) disable iff (RESET)
      (sync_reg.read_return_sel == `OPBUF_RET_STATUS) |=> (READ_BUS[15:4] == `OPBUF_STATUS_PAD))
      else $error("status return upper bits not zero");

   a_bus_one_wait: assert property (@(posedge CLOCK) disable iff (RESET)
      (AVS_READ && AVS_WAITREQUEST) |=> (!AVS_WAITREQUEST))
      else $error("read waited more than one cycle");

   a_float_msb_feed: assert property (@(posedge CLOCK) disable iff (RESET)
      (working_clock && shift_select == `OPBUF_SEL_LEFT && float_fitted_reg
       && !prev_reg.combined_arith_shift
       && prev_reg.general_purpose_ctl_code == `OPBUF_GPC_FLOAT_MSB)
      |=> (working_shift_reg[0] == $past(prev_reg.float_high_msb)))
      else $error("code five did not feed the float high msb");

   a_ctrl_write_lands: assert property (@(posedge CLOCK) disable iff (RESET)
      (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `OPBUF_ADDR_CTRL && AVS_BYTEENABLE[0])
      |=> (float_fitted_reg == $past(AVS_WRITEDATA[`OPBUF_CTRL_FLOAT_BIT])))
      else $error("control write did not land");

endmodule
`default_nettype wire

// File: tb/host_timing_model.sv
/*
 Host timing model: emits the processor timing pulses of one cycle.
 Assumes the bench raises go with a cycle length and waits for done.
*/
`timescale 1ns/100ps
`default_nettype none
module host_timing_model (
   input  wire logic       CLOCK,
   input  wire logic       go,
   input  wire logic [1:0] cyc_len,
   input  wire logic [1:0] gap,
   output logic      [2:0] pulses,
   output logic            done
);
   // ----------------------------------------------------------------
   // pulse sequencer
   // ----------------------------------------------------------------
   // one pulse, three clocks high, then a long low tail so the core settles
   task automatic fire(input int i);
      repeat (gap) @(posedge CLOCK);
      pulses <= 3'h1 << i;
      repeat (3) @(posedge CLOCK);
      pulses <= 3'h0;
      repeat (10) @(posedge CLOCK);
   endtask
   initial begin
      pulses = 3'h0;
      done = 1'b0;
   end
   // lengths a and b end in one pulse, length c carries two
   always begin
      @(posedge CLOCK);
      if (go) begin
         if (cyc_len == 2'h0) fire(0);
         else if (cyc_len == 2'h1) fire(1);
         else begin
            fire(0);
            fire(2);
         end
         done <= 1'b1;
         @(posedge CLOCK);
         done <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: tb/operand_buffer_shift_datapath_bench.sv
/*
 Self-checking bench of the operand buffer and shift datapath.
 Assumes the core, its package and the host timing model are compiled.
*/
`timescale 1ns/100ps
`default_nettype none
module operand_buffer_shift_datapath_bench;
   import opbuf_pkg::*;
   logic           clk = 1'b0;
   logic           rst = 1'b1;
   logic           go = 1'b0;
   logic           rd = 1'b0;
   logic           wr = 1'b0;
   logic           done, waitreq, fit;
   logic [1:0]     len, gap;
   logic [2:0]     pls;
   logic [3:0]     addr;
   logic [31:0]    wdat, rdat;
   logic [15:0]    rbus, e_buf, e_work;
   pin_in_t        ctl, pins;
   datapath_out_t  dp;
   logic [47:0]    q_dp[$];
   logic [31:0]    q_rd[$];
   int             num_errors, checks, cycles;

   // ----------------------------------------------------------------
   // clock, pins and instances
   // ----------------------------------------------------------------
   always #25 clk = ~clk;
   // pulses come from the host model, all other pins from the bench
   always_comb begin
      pins = ctl;
      pins.first_timing_pulse = pls[0];
      pins.second_timing_pulse = pls[1];
      pins.third_timing_pulse = pls[2];
   end
   operand_buffer_shift_datapath i_dut (.CLOCK(clk), .RESET(rst), .PINS(pins), .READ_BUS(rbus),
      .DATAPATH(dp), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(4'hf),
      .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(waitreq));
   host_timing_model i_host (.CLOCK(clk), .go(go), .cyc_len(len), .gap(gap), .pulses(pls), .done(done));

   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic compare(input logic [47:0] seen, input logic [47:0] want);
      checks++;
      if (seen !== want) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic close_out();
      // notes that never met their answer count as mismatches
      num_errors += q_dp.size() + q_rd.size();
      $display("counts: checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // watcher: pops the oldest note whenever a result appears, and the hang limit
   always @(posedge clk) begin
      if (done === 1'b1 && q_dp.size() > 0) compare({dp, rbus}, q_dp.pop_front());
      if (rd && waitreq === 1'b0 && q_rd.size() > 0) compare({16'h0, rdat}, {16'h0, q_rd.pop_front()});
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // drivers
   // ----------------------------------------------------------------
   // one bus request, held until waitrequest is sampled low; reads note d
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdat <= d;
      if (!w) q_rd.push_back(d);
      // no limit of its own; a wait that never sees waitrequest low is ended by the bench hang limit
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // one processor cycle with random controls, modelled pulse by pulse
   task automatic cyc(input int k);
      logic [63:0] r;
      pin_in_t     c;
      logic [15:0] nb, rb;
      logic        top, bot;
      int          j, p;
      r = {$urandom, $urandom};
      c = r[36:0];
      if (k % 4 == 0) c.general_purpose_ctl_code = 3'h5;
      // every eighth cycle a plain left shift, so the float msb source is reached
      if (k % 8 == 0) begin
         {c.shift_select_hi, c.shift_select_lo} = 2'h2;
         c.combined_arith_shift = 1'b0;
      end
      len = 2'($urandom % 3);
      gap = 2'($urandom % 4);
      bot = c.combined_arith_shift ? 1'b0 : (fit && c.general_purpose_ctl_code == 3'h5) ? c.float_high_msb :
            c.divide_active ? c.quotient_bit : 1'b0;
      for (j = 0; j < (len == 2'h2 ? 2 : 1); j++) begin
         p = (len == 2'h1) ? 1 : j * 2;
         top = c.multiply_active ? c.alu_result_bit0 : e_buf[0];
         nb = (p != 1 && c.buffer_load_en) ? c.cpu_data_mux : e_buf;
         if (p != 2) begin
            case ({c.shift_select_hi, c.shift_select_lo})
               2'h1: e_work = {top, e_work[15:1]};
               2'h2: e_work = {e_work[14:0], bot};
               2'h3: e_work = e_buf;
               default: e_work = e_work;
            endcase
         end
         e_buf = nb;
      end
      case (c.read_return_sel)
         2'h0: rb = {12'h0, c.extension_status_flags};
         2'h1: rb = e_work;
         2'h2: rb = {e_buf[14:0], e_work[15]};
         default: rb = e_buf;
      endcase
      q_dp.push_back({e_buf, e_work, rb});
      @(posedge clk);
      ctl <= c;
      go <= 1'b1;
      do begin
         @(posedge clk);
      end while (done !== 1'b1);
      go <= 1'b0;
      bus(1'b0, 4'hc, {16'h0, rb});
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      ctl = '0;
      addr = 4'h0;
      wdat = 32'h0;
      len = 2'h0;
      gap = 2'h0;
      e_buf = 16'h0;
      e_work = 16'h0;
      fit = 1'b0;
      num_errors = 0;
      checks = 0;
      cycles = 0;
      void'($urandom(32'hf3c602c6));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // reset values, an unmapped place and a read-only place
      bus(1'b0, 4'h0, 32'h0);
      bus(1'b0, 4'h4, 32'h0);
      bus(1'b0, 4'h8, 32'h0);
      bus(1'b0, 4'h2, 32'h0);
      bus(1'b1, 4'h4, 32'hffff);
      bus(1'b0, 4'h4, 32'h0);
      $display("test reset_map done");
      for (int k = 0; k < 30; k++) cyc(k);
      $display("test integer_only done");
      bus(1'b1, 4'h0, 32'h1);
      fit = 1'b1;
      bus(1'b0, 4'h0, 32'h1);
      for (int k = 30; k < 60; k++) cyc(k);
      $display("test float_fitted done");
      // second reset in mid-run clears everything again
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 4'h4, 32'h0);
      bus(1'b0, 4'h8, 32'h0);
      bus(1'b0, 4'h0, 32'h0);
      $display("test second_reset done");
      // let the watcher take the last answer first
      repeat (2) @(posedge clk);
      close_out();
   end
endmodule
`default_nettype wire
